// ===== rtl/token_node_pkg.sv
// Constants for the reset, start-up and diagnostic block of a token node.
// Assumes a single 25 MHz clock; all counts derive from it.
package token_node_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int CLK_PERIOD_NS = 40;
  // Crystal period assumed equal to the core clock period
  localparam int CRYSTAL_PERIOD_NS = 40;
  localparam int RESET_FILTER_PERIODS = 5;
  localparam int RESET_FILTER_CYCLES =
    (RESET_FILTER_PERIODS * CRYSTAL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DUP_TIME_SHORT_MS = 210;
  localparam int DUP_TIME_LONG_MS = 420;
  localparam int DUP_CYCLES_SHORT = DUP_TIME_SHORT_MS * (CLK_HZ / 1000);
  localparam int DUP_CYCLES_LONG = DUP_TIME_LONG_MS * (CLK_HZ / 1000);
  localparam int CFG_SOFT_RESET_BIT = 7;
  localparam int CFG_JOIN_ENABLE_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] ID_RESET = 8'h00;
  localparam logic [7:0] RAM_MARKER = 8'hd1;
  localparam logic [10:0] RAM_ADDR_MARKER = 11'h000;
  localparam logic [10:0] RAM_ADDR_ID = 11'h001;
  localparam logic [7:0] NAK_LIMIT_LONG = 8'h80;
  localparam logic [7:0] NAK_LIMIT_SHORT = 8'h04;
endpackage : token_node_pkg

// ===== rtl/token_node_reset_init_diag.sv
// Reset filter, start-up, bus type lock and diagnostic flags of a token node.
// Assumes all inputs synchronous to mclk; the protocol engine supplies event pulses.

// Overview of operation
// - Config bit 7 at one holds the device in software reset.
// - Software reset keeps bus mode, pointers, config and setup registers.
// - Hardware reset input filtered; pulses under five crystal periods ignored.
// - Any reset disables transmitter and restores identifier and flag defaults.
// - Core sleeps until a non-zero station identifier is written.
// - Identifier write causes RAM writes: D1 to 0, identifier to 1.
// - Awake core joins network only once join enable bit is set.
// - Duplicate flag set within 210 ms, or 420 ms per timeout selects.
// - Reading the duplicate identifier flag clears it.
// - Joining the network triggers a reconfiguration and self reconfig flag.
// - Tentative identifier write arms match watch; response sets tentative flag.
// - Token reception timer expiry sets the self reconfiguration flag once joined.
// - Reading diagnostic status clears the self reconfiguration flag.
// - Receive activity flag set on logic one at line receive input.
// - Token seen flag set by any token not sent by this node.
// - Excessive NAK flag set after 128 or 4 consecutive NAKs.
// - NAK limit select chooses threshold of 128 or 4.
// - Disable transmitter abandons send; available flag set on next token.
// - Clear flags resets excessive NAK; wrapping counter sets it again.
// - Odd-address write then read locks the host bus interface type.
module token_node_reset_init_diag #(
  parameter int DUP_SHORT_CYCLES = token_node_pkg::DUP_CYCLES_SHORT,
  parameter int DUP_LONG_CYCLES = token_node_pkg::DUP_CYCLES_LONG
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hard_reset_low_input,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_wdata,
  input wire logic setup_write,
  input wire logic [7:0] setup_wdata,
  input wire logic id_write,
  input wire logic [7:0] id_wdata,
  input wire logic tent_write,
  input wire logic [7:0] tent_wdata,
  input wire logic ptr_write,
  input wire logic [10:0] ptr_wdata,
  input wire logic host_write,
  input wire logic host_read,
  input wire logic host_addr_odd,
  input wire logic host_bus_type_in,
  input wire logic diag_read,
  input wire logic line_receive_input,
  input wire logic token_seen_event,
  input wire logic token_own_tx,
  input wire logic token_dest_match_event,
  input wire logic [7:0] token_dest_id,
  input wire logic response_seen,
  input wire logic dup_id_seen,
  input wire logic reconfig_event_flag_timer_expired,
  input wire logic nak_event,
  input wire logic ack_event,
  input wire logic cmd_clear_flags,
  input wire logic cmd_disable_tx,
  input wire logic token_to_me,
  output logic [7:0] cfg_reg,
  output logic [7:0] auxiliary_setup_register,
  output logic [7:0] station_identifier_register,
  output logic [10:0] addr_pointer,
  output logic bus_type_locked,
  output logic bus_type,
  output logic core_awake,
  output logic node_joined,
  output logic transmit_join_enable,
  output logic transmitter_enabled,
  output logic start_reconfig,
  output logic ram_we,
  output logic [10:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic self_reconfig_flag,
  output logic duplicate_identifier_flag,
  output logic tentative_match_flag,
  output logic receive_activity_flag,
  output logic token_seen_flag,
  output logic excessive_nak_flag,
  output logic transmitter_available_flag,
  output logic nak_interrupt
);
  typedef enum logic [1:0] {
    RAM_IDLE = 2'b00,
    RAM_MARK = 2'b01,
    RAM_ID = 2'b10
  } ram_state_t;
  logic [2:0] filt_cnt;
  logic hard_rst;
  logic soft_rst;
  logic any_rst;
  logic [31:0] dup_cnt;
  logic dup_armed;
  logic tent_armed;
  logic [7:0] tent_id;
  logic [7:0] nak_cnt;
  logic [7:0] nak_limit;
  logic odd_write_seen;
  logic tx_abandon;
  ram_state_t ram_state;

  // Glitch filter: reset is taken only after a held-low run
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      filt_cnt <= 3'h0;
      hard_rst <= 1'b1;
    end else if (hard_reset_low_input) begin
      filt_cnt <= 3'h0;
      hard_rst <= 1'b0;
    end else if (filt_cnt < 3'(token_node_pkg::RESET_FILTER_CYCLES - 1)) begin
      filt_cnt <= filt_cnt + 3'h1;
    end else begin
      hard_rst <= 1'b1;
    end
  end
  assign soft_rst = cfg_reg[token_node_pkg::CFG_SOFT_RESET_BIT];
  assign any_rst = hard_rst || soft_rst;
  assign transmit_join_enable = cfg_reg[token_node_pkg::CFG_JOIN_ENABLE_BIT];
  // Registers kept across software reset; only hardware reset clears them
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= token_node_pkg::CFG_RESET;
      auxiliary_setup_register <= token_node_pkg::SETUP_RESET;
      addr_pointer <= 11'h000;
    end else if (hard_rst) begin
      cfg_reg <= token_node_pkg::CFG_RESET;
      auxiliary_setup_register <= token_node_pkg::SETUP_RESET;
      addr_pointer <= 11'h000;
    end else begin
      // Soft reset leaves these alone so software can drop bit 7 again
      if (cfg_write) cfg_reg <= cfg_wdata;
      if (setup_write) auxiliary_setup_register <= setup_wdata;
      if (ptr_write) addr_pointer <= ptr_wdata;
    end
  end

  // Bus type lock: odd write followed by odd read; soft reset keeps it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      odd_write_seen <= 1'b0;
      bus_type_locked <= 1'b0;
      bus_type <= 1'b0;
    end else if (hard_rst) begin
      odd_write_seen <= 1'b0;
      bus_type_locked <= 1'b0;
      bus_type <= 1'b0;
    end else if (!bus_type_locked) begin
      if (host_write && host_addr_odd) odd_write_seen <= 1'b1;
      if (host_read && host_addr_odd && odd_write_seen) begin
        bus_type_locked <= 1'b1;
        bus_type <= host_bus_type_in;
      end
    end
  end

  // Station identifier and core wake; setup is expected to be loaded first
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      station_identifier_register <= token_node_pkg::ID_RESET;
      core_awake <= 1'b0;
    end else if (any_rst) begin
      station_identifier_register <= token_node_pkg::ID_RESET;
      core_awake <= 1'b0;
    end else if (id_write) begin
      station_identifier_register <= id_wdata;
      core_awake <= (id_wdata != 8'h00);
    end
  end

  // Two buffer writes after each identifier write taken in RAM_IDLE
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ram_state <= RAM_IDLE;
    end else if (any_rst) begin
      ram_state <= RAM_IDLE;
    end else begin
      case (ram_state)
        RAM_IDLE: if (id_write) ram_state <= RAM_MARK;
        RAM_MARK: ram_state <= RAM_ID;
        RAM_ID: ram_state <= RAM_IDLE;
        default: ram_state <= RAM_IDLE;
      endcase
    end
  end
  assign ram_we = (ram_state == RAM_MARK) || (ram_state == RAM_ID);
  assign ram_addr = (ram_state == RAM_ID) ? token_node_pkg::RAM_ADDR_ID
                                          : token_node_pkg::RAM_ADDR_MARKER;
  assign ram_wdata = (ram_state == RAM_ID) ? station_identifier_register
                                           : token_node_pkg::RAM_MARKER;
  // Join: awake core waits for join enable, then reconfigures once
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      node_joined <= 1'b0;
      start_reconfig <= 1'b0;
    end else if (any_rst) begin
      node_joined <= 1'b0;
      start_reconfig <= 1'b0;
    end else begin
      start_reconfig <= 1'b0;
      if (core_awake && transmit_join_enable && !node_joined) begin
        node_joined <= 1'b1;
        start_reconfig <= 1'b1;
      end else if (!transmit_join_enable) begin
        node_joined <= 1'b0;
      end else if (node_joined && reconfig_event_flag_timer_expired) begin
        start_reconfig <= 1'b1;
      end
    end
  end
  assign transmitter_enabled = node_joined && !any_rst;
  // Duplicate identifier probe window; limit depends on timeout selects
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dup_cnt <= 32'h0;
      dup_armed <= 1'b0;
      duplicate_identifier_flag <= 1'b0;
    end else if (any_rst) begin
      dup_cnt <= 32'h0;
      dup_armed <= 1'b0;
      duplicate_identifier_flag <= 1'b0;
    end else begin
      if (id_write) begin
        dup_cnt <= 32'h0;
        dup_armed <= (id_wdata != 8'h00);
      end else if (dup_armed) begin
        // Timeout select bits sit in setup bits 1:0; 1,1 picks short window
        if (dup_cnt >= 32'((auxiliary_setup_register[1:0] == 2'b11)
                           ? DUP_SHORT_CYCLES : DUP_LONG_CYCLES)) begin
          dup_armed <= 1'b0;
        end else begin
          dup_cnt <= dup_cnt + 32'h1;
        end
      end
      // Set wins over a simultaneous read clear
      if (dup_armed && dup_id_seen) duplicate_identifier_flag <= 1'b1;
      else if (diag_read) duplicate_identifier_flag <= 1'b0;
    end
  end

  // Tentative identifier match watch
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tent_id <= 8'h00;
      tent_armed <= 1'b0;
      tentative_match_flag <= 1'b0;
    end else if (any_rst) begin
      tent_id <= 8'h00;
      tent_armed <= 1'b0;
      tentative_match_flag <= 1'b0;
    end else if (tent_write) begin
      tent_id <= tent_wdata;
      tent_armed <= 1'b1;
      tentative_match_flag <= 1'b0;
    end else if (tent_armed && token_dest_match_event && response_seen
                 && token_dest_id == tent_id) begin
      tentative_match_flag <= 1'b1;
    end
  end

  // Sticky diagnostics; set beats the read clear of self reconfig
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      self_reconfig_flag <= 1'b0;
      receive_activity_flag <= 1'b0;
      token_seen_flag <= 1'b0;
    end else if (any_rst) begin
      self_reconfig_flag <= 1'b0;
      receive_activity_flag <= 1'b0;
      token_seen_flag <= 1'b0;
    end else begin
      if (start_reconfig) self_reconfig_flag <= 1'b1;
      else if (diag_read) self_reconfig_flag <= 1'b0;
      if (line_receive_input) receive_activity_flag <= 1'b1;
      if (token_seen_event && !token_own_tx) token_seen_flag <= 1'b1;
    end
  end
  assign nak_limit = auxiliary_setup_register[2] ? token_node_pkg::NAK_LIMIT_SHORT
                                                 : token_node_pkg::NAK_LIMIT_LONG;
  // Wrapping NAK counter; clear flags only drops the flag
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      nak_cnt <= 8'h00;
      excessive_nak_flag <= 1'b0;
      nak_interrupt <= 1'b0;
    end else if (any_rst) begin
      nak_cnt <= 8'h00;
      excessive_nak_flag <= 1'b0;
      nak_interrupt <= 1'b0;
    end else begin
      nak_interrupt <= 1'b0;
      if (ack_event || cmd_disable_tx) begin
        nak_cnt <= 8'h00;
      end else if (nak_event) begin
        if (nak_cnt + 8'h01 >= nak_limit) begin
          nak_cnt <= 8'h00;
          excessive_nak_flag <= 1'b1;
          nak_interrupt <= 1'b1;
        end else begin
          nak_cnt <= nak_cnt + 8'h01;
        end
      end
      if (cmd_clear_flags && !(nak_event && nak_cnt + 8'h01 >= nak_limit))
        excessive_nak_flag <= 1'b0;
    end
  end

  // Abandon pending send; available flag returns at the next token
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_abandon <= 1'b0;
      transmitter_available_flag <= 1'b1;
    end else if (any_rst) begin
      tx_abandon <= 1'b0;
      transmitter_available_flag <= 1'b1;
    end else if (cmd_disable_tx) begin
      tx_abandon <= 1'b1;
      transmitter_available_flag <= 1'b0; // Not available until the token returns
    end else if (tx_abandon && token_to_me) begin
      tx_abandon <= 1'b0;
      transmitter_available_flag <= 1'b1;
    end
  end

  a_soft_reset_sleeps: assert property (@(posedge mclk) disable iff (!reset_n)
    soft_rst |=> !core_awake && !transmitter_enabled)
    else $error("core awake during soft reset");
  a_soft_keeps_setup: assert property (@(posedge mclk) disable iff (!reset_n)
    soft_rst && !hard_rst && !setup_write |=> $stable(auxiliary_setup_register))
    else $error("setup changed by soft reset");
  a_glitch_filtered: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(hard_rst) |-> !$past(hard_reset_low_input, 1) && !$past(hard_reset_low_input, 2)
      && !$past(hard_reset_low_input, 3) && !$past(hard_reset_low_input, 4)
      && !$past(hard_reset_low_input, 5))
    else $error("short low pulse caused reset");
  a_zero_id_sleeps: assert property (@(posedge mclk) disable iff (!reset_n)
    id_write && id_wdata == 8'h00 |=> !core_awake)
    else $error("zero identifier woke core");
  a_ram_two_writes: assert property (@(posedge mclk) disable iff (!reset_n)
    id_write && !any_rst && ram_state == RAM_IDLE |=> ram_we && ram_wdata == 8'hd1
      && ram_addr == 11'h000 ##1 ram_we && ram_addr == 11'h001)
    else $error("identifier RAM writes wrong");
  a_join_gated: assert property (@(posedge mclk) disable iff (!reset_n)
    node_joined |-> transmit_join_enable || $past(transmit_join_enable))
    else $error("joined without enable");
  a_join_reconfig_event_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(node_joined) |=> self_reconfig_flag)
    else $error("join gave no self reconfig");
  a_diag_read_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    diag_read && !start_reconfig && !any_rst |=> !self_reconfig_flag)
    else $error("read did not clear self reconfig");
  a_rx_activity: assert property (@(posedge mclk) disable iff (!reset_n)
    line_receive_input && !any_rst |=> receive_activity_flag)
    else $error("receive activity missed");
  a_own_token_ignored: assert property (@(posedge mclk) disable iff (!reset_n)
    !token_seen_flag && token_own_tx && !any_rst |=> !token_seen_flag)
    else $error("own token counted");
  a_nak_limit_select: assert property (@(posedge mclk) disable iff (!reset_n)
    auxiliary_setup_register[2] && !any_rst && nak_cnt == 8'h03 && nak_event
      && !ack_event && !cmd_disable_tx |=> excessive_nak_flag && nak_interrupt)
    else $error("fourth NAK did not flag");

  c_core_wakes: cover property (@(posedge mclk) disable iff (!reset_n) $rose(core_awake));
  c_node_joins: cover property (@(posedge mclk) disable iff (!reset_n) $rose(node_joined));
  c_exc_nak: cover property (@(posedge mclk) disable iff (!reset_n) $rose(excessive_nak_flag));
  c_dup_flag: cover property (@(posedge mclk) disable iff (!reset_n)
    $rose(duplicate_identifier_flag));
endmodule : token_node_reset_init_diag

// ===== tb/token_net_model.sv
// Network-side model: protocol engine event pulses seen by the node.
// Assumes the bench calls fire() from its own sequence; drives on the falling edge.
module token_net_model (
  input wire logic mclk,
  output logic line_receive_input,
  output logic token_seen_event,
  output logic token_own_tx,
  output logic token_dest_match_event,
  output logic [7:0] token_dest_id,
  output logic response_seen,
  output logic dup_id_seen,
  output logic reconfig_event_flag_timer_expired,
  output logic nak_event,
  output logic ack_event,
  output logic token_to_me
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] ev = 10'h000;
  logic [7:0] dest = 8'h00;
  // One bit per event; the line idles low between frames
  assign {token_to_me, ack_event, nak_event, reconfig_event_flag_timer_expired, dup_id_seen} = ev[9:5];
  assign {response_seen, token_dest_match_event, token_own_tx} = ev[4:2];
  assign {token_seen_event, line_receive_input} = ev[1:0];
  assign token_dest_id = dest;
  // One-cycle event; a released id is inverted so a stale value never matches
  task automatic fire(input logic [9:0] m, input logic [7:0] id);
    @(negedge mclk);
    ev = m;
    dest = id;
    @(negedge mclk);
    ev = 10'h000;
    dest = ~id;
  endtask : fire
endmodule : token_net_model

// ===== tb/token_node_reset_init_diag_tb_top.sv
// Bench for the reset, start-up and diagnostic block of a token node.
// Assumes token_net_model beside it; host strobes driven on the falling edge.
module token_node_reset_init_diag_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic hard_reset_low_input = 1'b1;
  logic [9:0] st = 10'h000;
  logic [10:0] wd = 11'h000;
  logic host_addr_odd = 1'b0;
  logic host_bus_type_in = 1'b0;
  logic cfg_write, setup_write, id_write, tent_write, ptr_write, diag_read;
  logic cmd_clear_flags, cmd_disable_tx, host_write, host_read;
  logic [7:0] cfg_wdata, setup_wdata, id_wdata, tent_wdata, token_dest_id;
  logic [10:0] ptr_wdata, addr_pointer, ram_addr;
  logic line_receive_input, token_seen_event, token_own_tx, token_dest_match_event;
  logic response_seen, dup_id_seen, reconfig_event_flag_timer_expired, nak_event, ack_event, token_to_me;
  logic [7:0] cfg_reg, auxiliary_setup_register, station_identifier_register, ram_wdata;
  logic bus_type_locked, bus_type, core_awake, node_joined, transmit_join_enable;
  logic transmitter_enabled, start_reconfig, ram_we, self_reconfig_flag;
  logic duplicate_identifier_flag, tentative_match_flag, receive_activity_flag;
  logic token_seen_flag, excessive_nak_flag, transmitter_available_flag, nak_interrupt;
  int miscompares = 0;
  int comparisons = 0;
  int i;
  // Host strobes share one vector so a task raises exactly one of them
  assign {host_read, host_write, cmd_disable_tx, cmd_clear_flags} = st[9:6];
  assign {diag_read, ptr_write, tent_write, id_write, setup_write, cfg_write} = st[5:0];
  assign {cfg_wdata, setup_wdata, id_wdata, tent_wdata} = {4{wd[7:0]}};
  assign ptr_wdata = wd;

  token_node_reset_init_diag #(.DUP_SHORT_CYCLES(50), .DUP_LONG_CYCLES(100)) uut (
    .mclk, .reset_n, .hard_reset_low_input, .cfg_write, .cfg_wdata, .setup_write,
    .setup_wdata, .id_write, .id_wdata, .tent_write, .tent_wdata, .ptr_write, .ptr_wdata,
    .host_write, .host_read, .host_addr_odd, .host_bus_type_in, .diag_read,
    .line_receive_input, .token_seen_event, .token_own_tx, .token_dest_match_event,
    .token_dest_id, .response_seen, .dup_id_seen, .reconfig_event_flag_timer_expired, .nak_event,
    .ack_event, .cmd_clear_flags, .cmd_disable_tx, .token_to_me, .cfg_reg,
    .auxiliary_setup_register, .station_identifier_register, .addr_pointer,
    .bus_type_locked, .bus_type, .core_awake, .node_joined, .transmit_join_enable,
    .transmitter_enabled, .start_reconfig, .ram_we, .ram_addr, .ram_wdata,
    .self_reconfig_flag, .duplicate_identifier_flag, .tentative_match_flag,
    .receive_activity_flag, .token_seen_flag, .excessive_nak_flag,
    .transmitter_available_flag, .nak_interrupt);

  token_net_model net (
    .mclk, .line_receive_input, .token_seen_event, .token_own_tx, .token_dest_match_event,
    .token_dest_id, .response_seen, .dup_id_seen, .reconfig_event_flag_timer_expired, .nak_event,
    .ack_event, .token_to_me);

  // 25 MHz clock
  initial begin
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One-cycle host strobe, taken at the rising edge in between
  task automatic host(input int k, input logic [10:0] d);
    @(negedge mclk);
    st[k] = 1'b1;
    wd = d;
    @(negedge mclk);
    st = 10'h000;
  endtask : host

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // A hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    test_done();
  end

  initial begin
    cyc(2);
    reset_n = 1'b1;
    cyc(1);
    chk("avail", transmitter_available_flag, 1);
    chk("cfg", cfg_reg, 0);
    chk("awake", core_awake, 0);
    $display("test reset done");
    host_addr_odd = 1'b1;
    host_bus_type_in = 1'b1;
    host(8, 0);
    host(9, 0);
    cyc(1);
    chk("locked", bus_type_locked, 1);
    chk("bus type", bus_type, 1);
    host(4, 11'h123);
    host(1, 11'h007); // Setup before identifier
    host(2, 11'h000);
    cyc(2);
    chk("awake zero id", core_awake, 0);
    host(2, 11'h02a);
    chk("ram we 1", ram_we, 1);
    chk("ram addr 1", ram_addr, 0);
    chk("ram data 1", ram_wdata, 8'hd1);
    cyc(1);
    chk("ram addr 2", ram_addr, 1);
    chk("ram data 2", ram_wdata, 8'h2a);
    cyc(1);
    chk("ram idle", ram_we, 0);
    chk("awake", core_awake, 1);
    chk("no join", node_joined, 0);
    net.fire(10'h020, 0);
    for (i = 0; i < 50 && duplicate_identifier_flag !== 1'b1; i++) cyc(1);
    chk("dup set", duplicate_identifier_flag, 1);
    host(5, 0);
    chk("dup clear", duplicate_identifier_flag, 0);
    $display("test start-up done");
    net.fire(10'h006, 0);
    cyc(1);
    chk("own token", token_seen_flag, 0);
    chk("line idle", receive_activity_flag, 0);
    net.fire(10'h003, 0);
    cyc(1);
    chk("token", token_seen_flag, 1);
    chk("activity", receive_activity_flag, 1);
    host(3, 11'h05c);
    net.fire(10'h018, 8'h05d);
    net.fire(10'h010, 0);
    chk("tent other", tentative_match_flag, 0);
    net.fire(10'h018, 8'h05c);
    cyc(2);
    chk("tentative", tentative_match_flag, 1);
    $display("test diagnostics done");
    for (i = 0; i < 3; i++) net.fire(10'h080, 0);
    net.fire(10'h100, 0);
    for (i = 0; i < 3; i++) net.fire(10'h080, 0);
    chk("nak 3", excessive_nak_flag, 0);
    net.fire(10'h080, 0);
    chk("nak 4", excessive_nak_flag, 1);
    chk("nak irq", nak_interrupt, 1);
    host(6, 0);
    chk("nak cleared", excessive_nak_flag, 0);
    for (i = 0; i < 4; i++) net.fire(10'h080, 0);
    chk("nak wrap", excessive_nak_flag, 1);
    host(1, 11'h003);
    host(6, 0);
    for (i = 0; i < 127; i++) net.fire(10'h080, 0);
    chk("nak 127", excessive_nak_flag, 0);
    net.fire(10'h080, 0);
    chk("nak 128", excessive_nak_flag, 1);
    host(7, 0);
    chk("tx pending", transmitter_available_flag, 0);
    net.fire(10'h200, 0);
    cyc(1);
    chk("tx avail", transmitter_available_flag, 1);
    $display("test nak done");
    host(0, 11'h020); // Join enable set once the core is awake with its identifier
    cyc(1);
    chk("joined", node_joined, 1);
    chk("join enable", transmit_join_enable, 1);
    chk("tx enabled", transmitter_enabled, 1);
    chk("reconfig", start_reconfig, 1);
    cyc(1);
    chk("self reconfig_event_flag", self_reconfig_flag, 1);
    host(5, 0);
    chk("reconfig_event_flag read", self_reconfig_flag, 0);
    net.fire(10'h040, 0);
    cyc(1);
    chk("timer reconfig_event_flag", self_reconfig_flag, 1);
    $display("test join done");
    host(0, 11'h0a0);
    host(2, 11'h033);
    cyc(1);
    chk("soft id", station_identifier_register, 0);
    chk("soft tx", transmitter_enabled, 0);
    chk("soft cfg", cfg_reg, 8'ha0);
    chk("soft setup", auxiliary_setup_register, 3);
    chk("soft ptr", addr_pointer, 11'h123);
    chk("soft lock", bus_type_locked, 1);
    host(0, 11'h000);
    host(2, 11'h02b);
    cyc(1);
    chk("out of soft", station_identifier_register, 8'h2b);
    cyc(60); // Short probe window has closed by now
    net.fire(10'h020, 0);
    chk("dup late", duplicate_identifier_flag, 0);
    host(1, 11'h004); // Timeout selects other than 1,1 give the long window
    host(2, 11'h02c);
    cyc(60);
    net.fire(10'h020, 0);
    chk("dup long", duplicate_identifier_flag, 1);
    host(7, 0);
    chk("avail dropped", transmitter_available_flag, 0);
    $display("test soft reset done");
    hard_reset_low_input = 1'b0;
    cyc(2);
    hard_reset_low_input = 1'b1;
    cyc(6);
    chk("glitch", station_identifier_register, 8'h2c);
    chk("glitch avail", transmitter_available_flag, 0);
    hard_reset_low_input = 1'b0; // Held past the minimum width
    cyc(6);
    chk("hard id", station_identifier_register, 0);
    chk("hard setup", auxiliary_setup_register, 0);
    chk("hard dup", duplicate_identifier_flag, 0);
    hard_reset_low_input = 1'b1;
    cyc(6);
    chk("hard avail", transmitter_available_flag, 1);
    $display("test hard reset done");
    test_done();
  end
endmodule : token_node_reset_init_diag_tb_top
